// ==== pkg/clock_switch_pkg.sv ====
package clock_switch_pkg;
   // Source encodings
   localparam logic [2:0] SRC_FRC      = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
   localparam logic [2:0] SRC_PRI      = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
   localparam logic [2:0] SRC_SEC      = 3'h4;
   localparam logic [2:0] SRC_SLOW     = 3'h5;
   localparam logic [2:0] SRC_FRC_D16  = 3'h6;
   localparam logic [2:0] SRC_FRC_DN   = 3'h7;
   // Register byte addresses
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_TRIM    = 4'h4;
   localparam logic [3:0] ADDR_KEY     = 4'h8;
   // Unlock keys
   localparam logic [7:0] KEY_FIRST    = 8'h55;
   localparam logic [7:0] KEY_SECOND   = 8'hAA;
   // Control field positions
   localparam int CUR_LSB     = 12;
   localparam int NEXT_LSB    = 8;
   localparam int FREEZE_BIT  = 7;
   localparam int PINMAP_BIT  = 6;
   localparam int LOCK_BIT    = 5;
   localparam int FAIL_BIT    = 3;
   localparam int KEEP_BIT    = 1;
   localparam int REQ_BIT     = 0;
   // Counts
   localparam logic [3:0]  SETTLE_CYCLES  = 4'hA;
   localparam logic [10:0] STARTUP_CYCLES = 11'h400;
   localparam logic [15:0] RESET_CONTROL  = 16'h0000;
   localparam logic [15:0] RESET_TRIM     = 16'h0000;
endpackage : clock_switch_pkg

// ==== core/clock_switch_and_fail_monitor.sv ====
// Behaviour
// - Fuse one disables switching and monitor
// - Disabled: next ignored, current from fuse
// - Disabled: request bit ignored, reads zero
// - Equal sources: clear request, abort
// - Valid switch clears lock, fail flag
// - Enable target, wait timer and lock
// - Count ten new-clock cycles before swap
// - Done: clear request, copy next source
// - Power down old, keep slow/secondary
// - Processor keeps running during switch
// - Monitor keeps slow RC running awake
// - Failure: trap and fall back to RC
// - PLL failure falls back to RC PLL
// - Registers reset only on power-on
// - Startup timer counts 1024 oscillator cycles
`timescale 1ns/1ns
`default_nettype none
module clock_switch_and_fail_monitor
(
   // Clock and power-on reset
   input  wire  logic        mclk,
   input  wire  logic        rst,
   // Wishbone slave
   input  wire  logic        wb_cyc_i,
   input  wire  logic        wb_stb_i,
   input  wire  logic        wb_we_i,
   input  wire  logic [3:0]  wb_adr_i,
   input  wire  logic [3:0]  wb_sel_i,
   input  wire  logic [31:0] wb_dat_i,
   output logic        [31:0] wb_dat_o,
   output logic               wb_ack_o,
   // Fuses
   input  wire  logic        switch_monitor_fuse,
   input  wire  logic [2:0]  reset_source_fuse,
   // Oscillator status, already in mclk domain
   input  wire  logic [7:0]  osc_running,
   input  wire  logic        new_clock_tick,
   input  wire  logic        pll_locked,
   input  wire  logic        osc_failed,
   input  wire  logic        watchdog_enabled,
   input  wire  logic        sleep_mode,
   // Clock control
   output logic        [7:0] osc_enable,
   output logic        [2:0] clock_select,
   output logic              clock_fail_trap,
   output logic              source_select_freeze,
   output logic              pin_map_freeze,
   output logic        [5:0] trim_field
);
   import clock_switch_pkg::*;

   typedef enum {ST_IDLE, ST_START, ST_WAIT, ST_SETTLE} state_t;

   state_t      state, next_state;
   logic [2:0]  curSrc, next_curSrc;
   logic [2:0]  nextSrc, next_nextSrc;
   logic        switchReq, next_switchReq;
   logic        lockBit, next_lockBit;
   logic        failFlag, next_failFlag;
   logic        keepSec, next_keepSec;
   logic        freeze, next_freeze;
   logic        pinFreeze, next_pinFreeze;
   logic [5:0]  trim, next_trim;
   logic [1:0]  keyStage, next_keyStage;
   logic [10:0] startCnt, next_startCnt;
   logic [3:0]  settleCnt, next_settleCnt;
   logic [7:0]  oscEn, next_oscEn;
   logic        trap, next_trap;
   logic        ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic        fuseCaught, next_fuseCaught;
   logic        switchEn;
   logic        access, wr;
   logic [15:0] ctrlRead;

   assign switchEn = ~switch_monitor_fuse;
   assign access   = wb_cyc_i & wb_stb_i & ~ack;
   assign wr       = access & wb_we_i;

   function automatic logic uses_pll(input logic [2:0] s);
      uses_pll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
   endfunction : uses_pll

   function automatic logic is_crystal(input logic [2:0] s);
      is_crystal = (s == SRC_PRI) || (s == SRC_PRI_PLL) || (s == SRC_SEC);
   endfunction : is_crystal

   always_comb
   begin
      ctrlRead = 16'h0000;
      ctrlRead[CUR_LSB +: 3]  = curSrc;
      ctrlRead[NEXT_LSB +: 3] = nextSrc;
      ctrlRead[FREEZE_BIT]    = freeze;
      ctrlRead[PINMAP_BIT]    = pinFreeze;
      ctrlRead[LOCK_BIT]      = lockBit;
      ctrlRead[FAIL_BIT]      = failFlag;
      ctrlRead[KEEP_BIT]      = keepSec;
      ctrlRead[REQ_BIT]       = switchReq & switchEn;
   end

   always_comb
   begin
      next_state     = state;
      next_curSrc    = curSrc;
      next_nextSrc   = nextSrc;
      next_switchReq = switchReq;
      next_lockBit   = lockBit;
      next_failFlag  = failFlag;
      next_keepSec   = keepSec;
      next_freeze    = freeze;
      next_pinFreeze = pinFreeze;
      next_trim      = trim;
      next_keyStage  = keyStage;
      next_startCnt  = startCnt;
      next_settleCnt = settleCnt;
      next_oscEn     = oscEn;
      next_trap      = 1'b0;
      next_ack       = access;
      next_rdata     = rdata;
      next_fuseCaught = 1'b1;
      // Fuse caught once after power-on release
      if (!fuseCaught)
      begin
         next_curSrc  = reset_source_fuse;
         next_nextSrc = reset_source_fuse;
         next_oscEn   = 8'h00;
         next_oscEn[reset_source_fuse] = 1'b1;
      end
      // Bus access and unlock keys
      if (access)
      begin
         next_rdata = 32'h0000_0000;
         if (wb_adr_i == ADDR_CONTROL)
            next_rdata = {16'h0000, ctrlRead};
         else if (wb_adr_i == ADDR_TRIM)
            next_rdata = {26'h0, trim};
         else if (wb_adr_i == ADDR_KEY)
            next_rdata = {30'h0, keyStage};
         if (wr)
         begin
            next_keyStage = 2'h0;
            if (wb_adr_i == ADDR_KEY && wb_sel_i[0])
            begin
               if (keyStage == 2'h0 && wb_dat_i[7:0] == KEY_FIRST)
                  next_keyStage = 2'h1;
               else if (keyStage == 2'h1 && wb_dat_i[7:0] == KEY_SECOND)
                  next_keyStage = 2'h2;
            end
            else if (wb_adr_i == ADDR_CONTROL && keyStage == 2'h2)
            begin
               // Frozen selection blocks high byte and request
               if (wb_sel_i[1] && !freeze && state == ST_IDLE)
                  next_nextSrc = wb_dat_i[NEXT_LSB +: 3];
               if (wb_sel_i[0])
               begin
                  next_pinFreeze = wb_dat_i[PINMAP_BIT];
                  next_keepSec   = wb_dat_i[KEEP_BIT];
                  if (!wb_dat_i[FAIL_BIT])
                     next_failFlag = 1'b0;
                  if (!freeze)
                     next_freeze = wb_dat_i[FREEZE_BIT];
                  if (switchEn && !freeze && wb_dat_i[REQ_BIT])
                     next_switchReq = 1'b1;
               end
            end
            else if (wb_adr_i == ADDR_TRIM && wb_sel_i[0])
               next_trim = wb_dat_i[5:0];
         end
      end
      if (!switchEn)
         next_switchReq = 1'b0;
      // Switch sequence; the core runs on meanwhile
      case (state)
         ST_IDLE:
            if (switchReq && switchEn)
            begin
               if (nextSrc == curSrc)
                  next_switchReq = 1'b0;
               else
               begin
                  next_lockBit  = 1'b0;
                  next_failFlag = 1'b0;
                  next_state    = ST_START;
               end
            end
         ST_START:
         begin
            next_oscEn[nextSrc] = 1'b1;
            next_startCnt  = 11'h000;
            next_settleCnt = 4'h0;
            next_state     = ST_WAIT;
         end
         ST_WAIT:
         begin
            // Timer counts ticks of the oscillator being started
            if (osc_running[nextSrc] && is_crystal(nextSrc) && new_clock_tick
                && startCnt != STARTUP_CYCLES)
               next_startCnt = startCnt + 11'h001;
            if (osc_running[nextSrc]
                && (!is_crystal(nextSrc) || startCnt == STARTUP_CYCLES)
                && (!uses_pll(nextSrc) || pll_locked))
            begin
               next_lockBit = uses_pll(nextSrc) | is_crystal(nextSrc);
               next_state   = ST_SETTLE;
            end
         end
         ST_SETTLE:
         begin
            if (new_clock_tick)
               next_settleCnt = settleCnt + 4'h1;
            if (new_clock_tick && settleCnt == SETTLE_CYCLES - 4'h1)
            begin
               next_curSrc    = nextSrc;
               next_switchReq = 1'b0;
               next_oscEn     = 8'h00;
               next_oscEn[nextSrc] = 1'b1;
               next_state     = ST_IDLE;
            end
         end
         default:
            next_state = ST_IDLE;
      endcase
      // Survivors of the power-down
      if (keepSec)
         next_oscEn[SRC_SEC] = 1'b1;
      if ((watchdog_enabled || switchEn) && !sleep_mode)
         next_oscEn[SRC_SLOW] = 1'b1;
      // Fail-safe fallback wins over any pending switch
      if (switchEn && osc_failed && fuseCaught)
      begin
         next_trap      = 1'b1;
         next_failFlag  = 1'b1;
         next_switchReq = 1'b0;
         next_state     = ST_IDLE;
         next_curSrc    = uses_pll(curSrc) ? SRC_FRC_PLL : SRC_FRC;
         next_nextSrc   = next_curSrc;
         next_oscEn[next_curSrc] = 1'b1;
      end
   end

   // Only power-on reset reaches these flops
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state      <= ST_IDLE;
         curSrc     <= SRC_FRC;
         nextSrc    <= SRC_FRC;
         switchReq  <= RESET_CONTROL[REQ_BIT];
         lockBit    <= RESET_CONTROL[LOCK_BIT];
         failFlag   <= RESET_CONTROL[FAIL_BIT];
         keepSec    <= RESET_CONTROL[KEEP_BIT];
         freeze     <= RESET_CONTROL[FREEZE_BIT];
         pinFreeze  <= RESET_CONTROL[PINMAP_BIT];
         trim       <= RESET_TRIM[5:0];
         keyStage   <= 2'h0;
         startCnt   <= 11'h000;
         settleCnt  <= 4'h0;
         oscEn      <= 8'h00;
         trap       <= 1'b0;
         ack        <= 1'b0;
         rdata      <= 32'h0000_0000;
         fuseCaught <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         curSrc     <= next_curSrc;
         nextSrc    <= next_nextSrc;
         switchReq  <= next_switchReq;
         lockBit    <= next_lockBit;
         failFlag   <= next_failFlag;
         keepSec    <= next_keepSec;
         freeze     <= next_freeze;
         pinFreeze  <= next_pinFreeze;
         trim       <= next_trim;
         keyStage   <= next_keyStage;
         startCnt   <= next_startCnt;
         settleCnt  <= next_settleCnt;
         oscEn      <= next_oscEn;
         trap       <= next_trap;
         ack        <= next_ack;
         rdata      <= next_rdata;
         fuseCaught <= next_fuseCaught;
      end
   end

   assign wb_dat_o             = rdata;
   assign wb_ack_o             = ack;
   assign osc_enable           = oscEn;
   assign clock_select         = curSrc;
   assign clock_fail_trap      = trap;
   assign source_select_freeze = freeze;
   assign pin_map_freeze       = pinFreeze;
   assign trim_field           = trim;
endmodule : clock_switch_and_fail_monitor
`default_nettype wire

// ==== testbench/clock_switch_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module clock_switch_props
(
   // Clock, reset and bus
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Fuse and clock status
   input wire logic        switch_monitor_fuse,
   input wire logic        new_clock_tick,
   input wire logic        osc_failed,
   input wire logic [2:0]  clock_select,
   input wire logic        clock_fail_trap
);
   import clock_switch_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   req_zero_a: assert property (switch_monitor_fuse && wb_ack_o && !wb_we_i
      && wb_adr_i == ADDR_CONTROL |-> !wb_dat_o[REQ_BIT]) else $error("request read one");
   sel_frozen_a: assert property (switch_monitor_fuse && !$past(rst) && !$past(rst, 2)
      |-> $stable(clock_select)) else $error("select moved while disabled");
   no_trap_a: assert property (switch_monitor_fuse |-> !clock_fail_trap)
      else $error("trap while disabled");
   trap_on_fail_a: assert property (!switch_monitor_fuse && osc_failed && !$past(rst)
      |=> clock_fail_trap) else $error("no trap");
   fallback_a: assert property (clock_fail_trap
      |-> ##[0:2] (clock_select == SRC_FRC || clock_select == SRC_FRC_PLL))
      else $error("no fallback");
   sel_on_tick_a: assert property ($changed(clock_select) && !$past(rst) && !$past(rst, 2)
      |-> $past(new_clock_tick) || $past(osc_failed) || $past(clock_fail_trap))
      else $error("select moved without tick");
endmodule : clock_switch_props
bind clock_switch_and_fail_monitor clock_switch_props clock_switch_props_i
(
   .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .switch_monitor_fuse(switch_monitor_fuse), .new_clock_tick(new_clock_tick),
   .osc_failed(osc_failed), .clock_select(clock_select), .clock_fail_trap(clock_fail_trap)
);
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import clock_switch_pkg::*;
   logic        mclk = 1'h0, rst = 1'h1, cyc = 1'h0, we = 1'h0, fuse = 1'h1, tick = 1'h0;
   logic        pll = 1'h0, fail = 1'h0, ack, trap, sfrz, pfrz;
   logic        wdt = 1'h0, slp = 1'h0;
   logic [3:0]  adr = 4'h0, lanes = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [2:0]  rsrc = 3'h0, sel;
   logic [7:0]  running = 8'h0, oen;
   logic [5:0]  trim;
   int          num_errors = 0, checked = 0, cycles = 0, n;
   clock_switch_and_fail_monitor clock_switch_and_fail_monitor_i
   (
      .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(lanes), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .switch_monitor_fuse(fuse), .reset_source_fuse(rsrc), .osc_running(running),
      .new_clock_tick(tick), .pll_locked(pll), .osc_failed(fail), .watchdog_enabled(wdt),
      .sleep_mode(slp), .osc_enable(oen), .clock_select(sel), .clock_fail_trap(trap),
      .source_select_freeze(sfrz), .pin_map_freeze(pfrz), .trim_field(trim)
   );
   always #25 mclk = ~mclk;
   // Oscillators run once enabled; tick every other cycle
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      tick <= ~tick;
      running <= oen;
      pll <= oen[SRC_FRC_PLL] | oen[SRC_PRI_PLL];
      if (cycles == 20000)
      begin
         num_errors++;
         results();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask : chk
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
      int k;
      @(posedge mclk);
      cyc <= 1'h1;
      we <= w;
      adr <= a;
      lanes <= s;
      wdat <= d;
      k = 0;
      do
      begin
         @(posedge mclk);
         k++;
      end
      while (ack !== 1'h1 && k < 50);
      q = rdat;
      cyc <= 1'h0;
      if (k == 50)
         chk("ack", 32'h1, 32'h0);
   endtask : wb
   task automatic ctl(input logic [3:0] s, input logic [31:0] d);
      wb(1'h1, ADDR_KEY, 4'h1, 32'(KEY_FIRST));
      wb(1'h1, ADDR_KEY, 4'h1, 32'(KEY_SECOND));
      wb(1'h1, ADDR_CONTROL, s, d);
   endtask : ctl
   task automatic restart(input logic f, input logic [2:0] s);
      @(posedge mclk);
      rst <= 1'h1;
      fuse <= f;
      rsrc <= s;
      repeat (6) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
   endtask : restart
   task automatic swap(input logic [2:0] want, input int lo, input int hi);
      n = 0;
      while (sel !== want && n < 3000)
      begin
         @(posedge mclk);
         n++;
      end
      chk("swap time", 32'h1, 32'(n >= lo && n <= hi));
   endtask : swap
   task automatic failure(input logic [2:0] want);
      @(posedge mclk);
      fail <= 1'h1;
      @(posedge mclk);
      fail <= 1'h0;
      @(negedge mclk);
      chk("trap", 32'h1, 32'(trap));
      repeat (3) @(posedge mclk);
      chk("fallback", 32'(want), 32'(sel));
   endtask : failure
   task automatic disabled_mode();
      restart(1'h1, SRC_PRI);
      @(posedge mclk);
      chk("slow idle", 32'h0, 32'(oen[SRC_SLOW]));
      wdt <= 1'h1;
      slp <= 1'h1;
      repeat (2) @(posedge mclk);
      chk("slow asleep", 32'h0, 32'(oen[SRC_SLOW]));
      slp <= 1'h0;
      repeat (2) @(posedge mclk);
      chk("slow watchdog", 32'h1, 32'(oen[SRC_SLOW]));
      wdt <= 1'h0;
      wb(1'h0, ADDR_TRIM, 4'hF, 32'h0);
      chk("trim reset", 32'(RESET_TRIM), q);
      wb(1'h1, ADDR_TRIM, 4'h1, 32'h2A);
      chk("trim", 32'h2A, 32'(trim));
      wb(1'h0, 4'hC, 4'hF, 32'h0);
      chk("unmapped", 32'h0, q);
      ctl(4'h2, 32'h0400);
      ctl(4'h1, 32'h0041);
      chk("pin freeze", 32'h1, 32'(pfrz));
      wb(1'h0, ADDR_CONTROL, 4'hF, 32'h0);
      chk("current", 32'(SRC_PRI), 32'(q[14:12]));
      chk("request", 32'h0, 32'(q[0]));
      chk("select", 32'(SRC_PRI), 32'(sel));
   endtask : disabled_mode
   task automatic switch_primary();
      restart(1'h0, SRC_FRC);
      wb(1'h1, ADDR_KEY, 4'h1, 32'(KEY_FIRST));
      wb(1'h1, ADDR_KEY, 4'h1, 32'h12);
      wb(1'h1, ADDR_CONTROL, 4'h2, 32'h0200);
      wb(1'h0, ADDR_CONTROL, 4'hF, 32'h0);
      chk("bad key", 32'(SRC_FRC), 32'(q[10:8]));
      ctl(4'h2, 32'h0200);
      ctl(4'h1, 32'h0001);
      wb(1'h0, ADDR_CONTROL, 4'hF, 32'h0);
      chk("busy request", 32'h1, 32'(q[0]));
      swap(SRC_PRI, 2060, 2110);
      wb(1'h0, ADDR_CONTROL, 4'hF, 32'h0);
      chk("current", 32'(SRC_PRI), 32'(q[14:12]));
      chk("request", 32'h0, 32'(q[0]));
      chk("old off", 32'h0, 32'(oen[SRC_FRC]));
      chk("slow kept", 32'h1, 32'(oen[SRC_SLOW]));
   endtask : switch_primary
   task automatic redundant();
      ctl(4'h1, 32'h0001);
      repeat (2) @(posedge mclk);
      wb(1'h0, ADDR_CONTROL, 4'hF, 32'h0);
      chk("aborted", 32'h0, 32'(q[0]));
      chk("kept", 32'(SRC_PRI), 32'(sel));
   endtask : redundant
   task automatic fail_and_pll();
      failure(SRC_FRC);
      wb(1'h0, ADDR_CONTROL, 4'hF, 32'h0);
      chk("fail flag", 32'h1, 32'(q[3]));
      ctl(4'h2, 32'h0100);
      ctl(4'h1, 32'h000B);
      swap(SRC_FRC_PLL, 18, 40);
      wb(1'h0, ADDR_CONTROL, 4'hF, 32'h0);
      chk("fail clear", 32'h0, 32'(q[3]));
      chk("lock", 32'h1, 32'(q[5]));
      chk("sec kept", 32'h1, 32'(oen[SRC_SEC]));
      failure(SRC_FRC_PLL);
      ctl(4'h1, 32'h0080);
      chk("freeze", 32'h1, 32'(sfrz));
      ctl(4'h2, 32'h0000);
      wb(1'h0, ADDR_CONTROL, 4'hF, 32'h0);
      chk("frozen next", 32'(SRC_FRC_PLL), 32'(q[10:8]));
   endtask : fail_and_pll
   task automatic results();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   initial
   begin
      disabled_mode();
      switch_primary();
      redundant();
      fail_and_pll();
      results();
   end
endmodule : testbench
`default_nettype wire
